// file: core/iepm_ctl.sv
`timescale 1ns/1ps
module iepm_ctl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Link to device
  iepm_if.ctl lnk
);
  logic wr_ph;
  logic [7:0] wr_addr;
  logic [15:0] flags;

  // Address phase capture
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ph <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_ph <= hsel && hwrite && htrans == iepm_pkg::HTRANS_NONSEQ;
      wr_addr <= haddr;
    end
  end

  // Flag sources; software clears by writing them
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags <= 16'h0003;
      lnk.mask_wr <= 1'b0;
      lnk.mask_wdata <= 8'h00;
      lnk.idle_req <= 1'b0;
      lnk.pdown_req <= 1'b0;
    end
    else
    begin
      lnk.mask_wr <= 1'b0;
      lnk.idle_req <= 1'b0;
      lnk.pdown_req <= 1'b0;
      if (wr_ph && wr_addr == iepm_pkg::AHB_MASK)
      begin
        lnk.mask_wr <= 1'b1;
        lnk.mask_wdata <= hwdata[7:0] & iepm_pkg::MASK_WMASK;
      end
      if (wr_ph && wr_addr == iepm_pkg::AHB_FLAGS)
        flags <= hwdata[15:0];
      if (wr_ph && wr_addr == iepm_pkg::AHB_MODE)
      begin
        lnk.idle_req <= hwdata[0];
        lnk.pdown_req <= hwdata[1];
      end
    end
  end

  // Flag bits drive the link directly, pins active low
  always_comb
  begin
    lnk.ext_irq_pin0 = flags[0];
    lnk.ext_irq_pin1 = flags[1];
    lnk.tmr0_ovf_flag = flags[2];
    lnk.tmr1_ovf_flag = flags[3];
    lnk.tmr2_ovf_flag = flags[4];
    lnk.tmr2_ext_flag = flags[5];
    lnk.uart_rx_done = flags[6];
    lnk.uart_tx_done = flags[7];
    lnk.spi_xfer_done_flag = flags[8];
    lnk.spi_irq_on = flags[9];
  end

  // Read data, one wait-free cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      case (haddr)
        iepm_pkg::AHB_MASK: hrdata <= {24'h000000, lnk.mask_rdata};
        iepm_pkg::AHB_FLAGS: hrdata <= {16'h0000, flags};
        iepm_pkg::AHB_MODE: hrdata <= {30'h00000000, lnk.pm_state};
        iepm_pkg::AHB_STATUS: hrdata <= {16'h0000, lnk.ram_block,
          lnk.osc_stop, lnk.cpu_halt, lnk.addr_latch_strobe,
          lnk.prog_store_rd_strobe, lnk.port0_float, lnk.port2_addr,
          lnk.isr_start, 2'h0, lnk.irq_pending};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule : iepm_ctl

// file: core/iepm_dev.sv
`timescale 1ns/1ps
module iepm_dev #(
  parameter bit EXT_PROG = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link to controller
  iepm_if.dev lnk,
  // Warm reset request while idle
  input wire logic hw_rst_req
);
  logic [7:0] irq_mask_reg;
  logic [2:0] state_cnt;
  logic [1:0] p0_s;
  logic [1:0] p1_s;
  logic [5:0] req_raw;
  logic [5:0] req_smp;
  logic t01_late;
  logic [3:0] rst_win;
  logic pin_low_seen;
  logic pin_prev;
  iepm_pkg::iepm_pm_t pm;
  logic gate;
  logic ext_wake;

  localparam int IEPM_CHECK_SRC = 6;
  // Vector width is fixed by the pending port
  if (IEPM_CHECK_SRC != iepm_pkg::NUM_SRC)
  begin : g_bad_src
    $error("source count mismatch");
  end

  // Pin synchronisers (active low pins)
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p0_s <= 2'h3;
      p1_s <= 2'h3;
    end
    else
    begin
      p0_s <= {p0_s[0], lnk.ext_irq_pin0};
      p1_s <= {p1_s[0], lnk.ext_irq_pin1};
    end
  end

  // Mask register; bit 6 reads zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_reg <= iepm_pkg::MASK_RESET;
    else if (lnk.mask_wr)
      irq_mask_reg <= lnk.mask_wdata & iepm_pkg::MASK_WMASK;
  end

  // Machine cycle state counter; frozen while oscillator stopped
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_cnt <= 3'h0;
    else if (pm != iepm_pkg::PM_PDOWN)
    begin
      if (state_cnt == iepm_pkg::LAST_STATE)
        state_cnt <= 3'h0;
      else
        state_cnt <= state_cnt + 3'h1;
    end
  end

  // Flags are level inputs; device never clears them
  always_comb
  begin
    req_raw = '0;
    req_raw[iepm_pkg::EX0_BIT] = ~p0_s[1];
    req_raw[iepm_pkg::ET0_BIT] = lnk.tmr0_ovf_flag;
    req_raw[iepm_pkg::EX1_BIT] = ~p1_s[1];
    req_raw[iepm_pkg::ET1_BIT] = lnk.tmr1_ovf_flag;
    req_raw[iepm_pkg::ES_BIT] = lnk.uart_rx_done | lnk.uart_tx_done |
      (lnk.spi_xfer_done_flag & lnk.spi_irq_on);
    req_raw[iepm_pkg::ET2_BIT] = lnk.tmr2_ovf_flag |
      lnk.tmr2_ext_flag;
  end

  // Timer 0/1 late-phase flag; both are sampled at LAST_STATE whether or not it is set
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      t01_late <= 1'b0;
    else if (state_cnt == iepm_pkg::LATE_STATE)
      t01_late <= 1'b1;
    else if (state_cnt == iepm_pkg::LAST_STATE)
      t01_late <= 1'b0;
  end

  // Sampling of requests
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      req_smp <= '0;
    else
    begin
      req_smp[iepm_pkg::EX0_BIT] <= req_raw[iepm_pkg::EX0_BIT];
      req_smp[iepm_pkg::EX1_BIT] <= req_raw[iepm_pkg::EX1_BIT];
      req_smp[iepm_pkg::ES_BIT] <= req_raw[iepm_pkg::ES_BIT];
      if (state_cnt == iepm_pkg::LAST_STATE && !t01_late)
      begin
        req_smp[iepm_pkg::ET0_BIT] <= req_raw[iepm_pkg::ET0_BIT];
        req_smp[iepm_pkg::ET1_BIT] <= req_raw[iepm_pkg::ET1_BIT];
      end
      else if (state_cnt == iepm_pkg::LAST_STATE)
      begin
        req_smp[iepm_pkg::ET0_BIT] <= req_raw[iepm_pkg::ET0_BIT];
        req_smp[iepm_pkg::ET1_BIT] <= req_raw[iepm_pkg::ET1_BIT];
      end
      if (state_cnt == iepm_pkg::EARLY_STATE)
        req_smp[iepm_pkg::ET2_BIT] <= req_raw[iepm_pkg::ET2_BIT];
    end
  end

  assign gate = irq_mask_reg[iepm_pkg::GATE_BIT];
  assign ext_wake = gate &
    ((irq_mask_reg[iepm_pkg::EX0_BIT] & ~p0_s[1]) |
     (irq_mask_reg[iepm_pkg::EX1_BIT] & ~p1_s[1]));

  // Pending requests toward the CPU
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      lnk.irq_pending <= '0;
    else if (pm == iepm_pkg::PM_PDOWN)
      lnk.irq_pending <= '0;
    else
      lnk.irq_pending <= {6{gate}} & irq_mask_reg[5:0] & req_smp;
  end

  // Power mode machine
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pm <= iepm_pkg::PM_RUN;
    else
    begin
      case (pm)
        iepm_pkg::PM_RUN:
          if (lnk.pdown_req)
            pm <= iepm_pkg::PM_PDOWN;
          else if (lnk.idle_req)
            pm <= iepm_pkg::PM_IDLE;
        iepm_pkg::PM_IDLE:
          if (|lnk.irq_pending || rst_win == 4'h1)
            pm <= iepm_pkg::PM_RUN;
        iepm_pkg::PM_PDOWN:
          if (pin_low_seen && !pin_prev && !ext_wake)
            pm <= iepm_pkg::PM_RUN;
        default:
          pm <= iepm_pkg::PM_RUN;
      endcase
    end
  end

  // Wake by pin held low, leave at rising edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_low_seen <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_prev <= ext_wake;
      if (pm != iepm_pkg::PM_PDOWN)
        pin_low_seen <= 1'b0;
      else if (ext_wake)
        pin_low_seen <= 1'b1;
    end
  end

  // Reset exit from idle: window with RAM blocked
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_win <= 4'h0;
    else if (pm == iepm_pkg::PM_IDLE && hw_rst_req && rst_win == 4'h0)
      rst_win <= 4'(iepm_pkg::IDLE_RST_CLKS);
    else if (rst_win != 4'h0)
      rst_win <= rst_win - 4'h1;
  end

  // Registered outputs and pin states
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lnk.mask_rdata <= 8'h00;
      lnk.pm_state <= 2'h0;
      lnk.cpu_halt <= 1'b0;
      lnk.osc_stop <= 1'b0;
      lnk.ram_block <= 1'b0;
      lnk.addr_latch_strobe <= 1'b1;
      lnk.prog_store_rd_strobe <= 1'b1;
      lnk.port0_float <= 1'b0;
      lnk.port2_addr <= 1'b0;
      lnk.isr_start <= 1'b0;
    end
    else
    begin
      lnk.mask_rdata <= irq_mask_reg;
      lnk.pm_state <= pm;
      lnk.cpu_halt <= pm != iepm_pkg::PM_RUN;
      lnk.osc_stop <= pm == iepm_pkg::PM_PDOWN;
      lnk.ram_block <= rst_win != 4'h0;
      lnk.addr_latch_strobe <= pm != iepm_pkg::PM_PDOWN;
      lnk.prog_store_rd_strobe <= pm != iepm_pkg::PM_PDOWN;
      lnk.port0_float <= EXT_PROG && pm != iepm_pkg::PM_RUN;
      lnk.port2_addr <= EXT_PROG && pm == iepm_pkg::PM_IDLE;
      lnk.isr_start <= pm == iepm_pkg::PM_PDOWN && pin_low_seen &&
        !pin_prev && !ext_wake;
    end
  end
endmodule : iepm_dev

// file: core/iepm_if.sv
`timescale 1ns/1ps
interface iepm_if;
  // Mask register port
  logic mask_wr;
  logic [7:0] mask_wdata;
  logic [7:0] mask_rdata;
  // Raw request sources
  logic ext_irq_pin0;
  logic ext_irq_pin1;
  logic tmr0_ovf_flag;
  logic tmr1_ovf_flag;
  logic tmr2_ovf_flag;
  logic tmr2_ext_flag;
  logic uart_rx_done;
  logic uart_tx_done;
  logic spi_xfer_done_flag;
  logic spi_irq_on;
  // Power mode requests
  logic idle_req;
  logic pdown_req;
  // Device results
  logic [5:0] irq_pending;
  logic [1:0] pm_state;
  logic cpu_halt;
  logic osc_stop;
  logic ram_block;
  logic addr_latch_strobe;
  logic prog_store_rd_strobe;
  logic port0_float;
  logic port2_addr;
  logic isr_start;
  modport dev (
    input mask_wr, mask_wdata, ext_irq_pin0, ext_irq_pin1,
    input tmr0_ovf_flag, tmr1_ovf_flag, tmr2_ovf_flag, tmr2_ext_flag,
    input uart_rx_done, uart_tx_done, spi_xfer_done_flag, spi_irq_on,
    input idle_req, pdown_req,
    output mask_rdata, irq_pending, pm_state, cpu_halt, osc_stop,
    output ram_block, addr_latch_strobe, prog_store_rd_strobe,
    output port0_float, port2_addr, isr_start
  );
  modport ctl (
    output mask_wr, mask_wdata, ext_irq_pin0, ext_irq_pin1,
    output tmr0_ovf_flag, tmr1_ovf_flag, tmr2_ovf_flag, tmr2_ext_flag,
    output uart_rx_done, uart_tx_done, spi_xfer_done_flag, spi_irq_on,
    output idle_req, pdown_req,
    input mask_rdata, irq_pending, pm_state, cpu_halt, osc_stop,
    input ram_block, addr_latch_strobe, prog_store_rd_strobe,
    input port0_float, port2_addr, isr_start
  );
endinterface : iepm_if

// file: core/iepm_pkg.sv
package iepm_pkg;
  // Mask register
  localparam logic [7:0] MASK_ADDR = 8'ha8;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int EX0_BIT = 0;
  localparam int ET0_BIT = 1;
  localparam int EX1_BIT = 2;
  localparam int ET1_BIT = 3;
  localparam int ES_BIT = 4;
  localparam int ET2_BIT = 5;
  localparam int RSV_BIT = 6;
  localparam int GATE_BIT = 7;
  localparam logic [7:0] MASK_WMASK = 8'hbf;
  localparam int NUM_SRC = 6;
  // Machine cycle: 12 oscillator periods, 6 core clocks, 2 phases each
  localparam int STATES_PER_CYC = 6;
  localparam logic [2:0] LATE_STATE = 3'h4;
  localparam logic [2:0] EARLY_STATE = 3'h1;
  localparam logic [2:0] LAST_STATE = 3'h5;
  // Reset exit from idle may run up to two machine cycles
  localparam int IDLE_RST_CYC = 2;
  localparam int IDLE_RST_CLKS = IDLE_RST_CYC * STATES_PER_CYC;
  // AHB-Lite map of the controller's own registers
  localparam logic [7:0] AHB_MASK = 8'h00;
  localparam logic [7:0] AHB_FLAGS = 8'h04;
  localparam logic [7:0] AHB_MODE = 8'h08;
  localparam logic [7:0] AHB_STATUS = 8'h0c;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  typedef enum logic [1:0]
  {
    PM_RUN = 2'b00,
    PM_IDLE = 2'b01,
    PM_PDOWN = 2'b10
  } iepm_pm_t;
endpackage : iepm_pkg

// file: verification/iepm_asserts.sv
`timescale 1ns/1ps
module iepm_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched link signals
  input wire logic [7:0] mask_rdata,
  input wire logic tmr0_ovf_flag,
  input wire logic tmr2_ovf_flag,
  input wire logic tmr2_ext_flag,
  input wire logic uart_rx_done,
  input wire logic uart_tx_done,
  input wire logic spi_xfer_done_flag,
  input wire logic spi_irq_on,
  input wire logic idle_req,
  input wire logic [5:0] irq_pending,
  input wire logic [1:0] pm_state,
  input wire logic cpu_halt,
  input wire logic osc_stop,
  input wire logic ram_block,
  input wire logic addr_latch_strobe,
  input wire logic prog_store_rd_strobe,
  input wire logic port0_float,
  input wire logic port2_addr,
  input wire logic isr_start
);
  logic t2_req;
  logic ser_req;
  assign t2_req = tmr2_ovf_flag || tmr2_ext_flag;
  assign ser_req = uart_rx_done || uart_tx_done ||
    (spi_xfer_done_flag && spi_irq_on);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  gate_off_a: assert property (!mask_rdata[7] [*8] |-> !(|irq_pending))
    else $error("pending with gate off");
  mask_needed_a: assert property ((irq_pending & ~mask_rdata[5:0] &
    ~$past(mask_rdata[5:0])) == 6'h00)
    else $error("pending without enable");
  t2_or_a: assert property ((mask_rdata[7] && mask_rdata[5] && t2_req) [*8]
    |-> irq_pending[5])
    else $error("timer 2 request lost");
  serial_or_a: assert property ((mask_rdata[7] && mask_rdata[4] &&
    ser_req) [*8] |-> irq_pending[4])
    else $error("serial request lost");
  serial_none_a: assert property (!ser_req [*8] |-> !irq_pending[4])
    else $error("serial pending without term");
  t0_sample_a: assert property ((mask_rdata[7] && mask_rdata[1] &&
    tmr0_ovf_flag) [*8] |-> irq_pending[1])
    else $error("timer 0 request lost");
  idle_enter_a: assert property (idle_req && pm_state == iepm_pkg::PM_RUN
    |-> ##[1:3] pm_state == iepm_pkg::PM_IDLE)
    else $error("idle not entered");
  idle_pins_a: assert property (pm_state == iepm_pkg::PM_IDLE [*2] |->
    cpu_halt && !osc_stop && addr_latch_strobe && prog_store_rd_strobe &&
    port0_float && port2_addr)
    else $error("idle outputs wrong");
  pdown_pins_a: assert property (pm_state == iepm_pkg::PM_PDOWN [*2] |->
    osc_stop && !addr_latch_strobe && !prog_store_rd_strobe &&
    port0_float && !port2_addr)
    else $error("power-down outputs wrong");
  idle_exit_a: assert property (pm_state == iepm_pkg::PM_IDLE &&
    (|irq_pending) |-> ##[1:3] pm_state == iepm_pkg::PM_RUN)
    else $error("idle not left on interrupt");
  ram_hold_a: assert property ($rose(ram_block) |-> ram_block [*8]
    ##[1:8] !ram_block)
    else $error("ram block window wrong");
  isr_pulse_a: assert property (isr_start |=> !isr_start)
    else $error("service start not a pulse");
endmodule : iepm_asserts

// file: verification/irq_enable_and_power_modes_tb_top.sv
`timescale 1ns/1ps
module irq_enable_and_power_modes_tb_top;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic hw_rst_req = 1'h0;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] rd;
  int errors = 0;
  int num_checks = 0;
  iepm_if lnk ();
  iepm_dev i_iepm_dev (.mclk(mclk), .rst_n(rst_n), .lnk(lnk.dev),
    .hw_rst_req(hw_rst_req));
  iepm_ctl i_iepm_ctl (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .lnk(lnk.ctl));
  iepm_asserts i_iepm_asserts (.mclk(mclk), .rst_n(rst_n),
    .mask_rdata(lnk.mask_rdata), .tmr0_ovf_flag(lnk.tmr0_ovf_flag),
    .tmr2_ovf_flag(lnk.tmr2_ovf_flag), .tmr2_ext_flag(lnk.tmr2_ext_flag),
    .uart_rx_done(lnk.uart_rx_done), .uart_tx_done(lnk.uart_tx_done),
    .spi_xfer_done_flag(lnk.spi_xfer_done_flag),
    .spi_irq_on(lnk.spi_irq_on), .idle_req(lnk.idle_req),
    .irq_pending(lnk.irq_pending), .pm_state(lnk.pm_state),
    .cpu_halt(lnk.cpu_halt), .osc_stop(lnk.osc_stop),
    .ram_block(lnk.ram_block), .addr_latch_strobe(lnk.addr_latch_strobe),
    .prog_store_rd_strobe(lnk.prog_store_rd_strobe),
    .port0_float(lnk.port0_float), .port2_addr(lnk.port2_addr),
    .isr_start(lnk.isr_start));
  always #25 mclk = ~mclk;
  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  // One single AHB-Lite transfer, called right after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= iepm_pkg::HTRANS_NONSEQ;
    @(posedge mclk);
    while (hreadyout !== 1'h1)
      @(posedge mclk);
    htrans <= iepm_pkg::HTRANS_IDLE;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'h1)
      @(posedge mclk);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'h1, d, r);
    // Link registers settle two edges after the data phase
    repeat (3) @(posedge mclk);
  endtask : wr
  function automatic logic [5:0] src_terms();
    return {lnk.tmr2_ovf_flag | lnk.tmr2_ext_flag,
      lnk.uart_rx_done | lnk.uart_tx_done |
      (lnk.spi_xfer_done_flag & lnk.spi_irq_on), lnk.tmr1_ovf_flag,
      ~lnk.ext_irq_pin1, lnk.tmr0_ovf_flag, ~lnk.ext_irq_pin0};
  endfunction : src_terms
  task automatic t_regs();
    xfer(iepm_pkg::AHB_MASK, 1'h0, 32'h0, rd);
    chk("mask reset", {24'h0, iepm_pkg::MASK_RESET}, rd);
    wr(iepm_pkg::AHB_MASK, 32'hff);
    xfer(iepm_pkg::AHB_MASK, 1'h0, 32'h0, rd);
    chk("mask bit 6", 32'hbf, rd);
    wr(8'h10, 32'hffff);
    xfer(8'h10, 1'h0, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
  endtask : t_regs
  task automatic t_gate();
    wr(iepm_pkg::AHB_FLAGS, 32'h3fc);
    for (int i = 0; i < iepm_pkg::NUM_SRC; i++)
    begin
      wr(iepm_pkg::AHB_MASK, 32'h80 | (32'h1 << i));
      repeat (14) @(posedge mclk);
      chk("one enabled", 32'h1 << i, {26'h0, lnk.irq_pending});
      wr(iepm_pkg::AHB_MASK, 32'h1 << i);
      repeat (14) @(posedge mclk);
      chk("gate off", 32'h0, {26'h0, lnk.irq_pending});
    end
    xfer(iepm_pkg::AHB_FLAGS, 1'h0, 32'h0, rd);
    chk("flags kept", 32'h3fc, rd);
  endtask : t_gate
  task automatic t_terms();
    logic [9:0] tbl [8] = '{10'h003, 10'h013, 10'h023, 10'h043, 10'h083,
      10'h103, 10'h203, 10'h30f};
    wr(iepm_pkg::AHB_MASK, 32'hbf);
    foreach (tbl[k])
    begin
      wr(iepm_pkg::AHB_FLAGS, {22'h0, tbl[k]});
      repeat (14) @(posedge mclk);
      chk("terms", {26'h0, src_terms()}, {26'h0, lnk.irq_pending});
    end
  endtask : t_terms
  task automatic t_idle();
    wr(iepm_pkg::AHB_FLAGS, 32'h3);
    wr(iepm_pkg::AHB_MASK, 32'h81);
    wr(iepm_pkg::AHB_MODE, 32'h1);
    repeat (4) @(posedge mclk);
    chk("idle", {3'h7, 27'h0, 2'h1}, {lnk.cpu_halt,
      lnk.addr_latch_strobe, lnk.prog_store_rd_strobe, 27'h0, lnk.pm_state});
    xfer(iepm_pkg::AHB_MASK, 1'h0, 32'h0, rd);
    chk("idle mask kept", 32'h81, rd);
    wr(iepm_pkg::AHB_FLAGS, 32'h2);
    repeat (14) @(posedge mclk);
    chk("idle exit", 32'h0, {30'h0, lnk.pm_state});
    wr(iepm_pkg::AHB_FLAGS, 32'h3);
  endtask : t_idle
  task automatic t_idle_rst();
    int n;
    n = 0;
    wr(iepm_pkg::AHB_MODE, 32'h1);
    // No port write follows idle entry
    repeat (4) @(posedge mclk);
    hw_rst_req <= 1'h1;
    @(posedge mclk);
    hw_rst_req <= 1'h0;
    repeat (40)
    begin
      @(posedge mclk);
      n += (lnk.ram_block === 1'h1);
    end
    chk("ram block", iepm_pkg::IDLE_RST_CLKS, n);
  endtask : t_idle_rst
  task automatic t_pdown();
    int n;
    n = 0;
    wr(iepm_pkg::AHB_MASK, 32'h81);
    wr(iepm_pkg::AHB_MODE, 32'h2);
    repeat (4) @(posedge mclk);
    chk("pdown", {lnk.osc_stop, lnk.addr_latch_strobe,
      lnk.prog_store_rd_strobe, lnk.port0_float, lnk.port2_addr},
      5'h12);
    wr(iepm_pkg::AHB_FLAGS, 32'h2);
    repeat (20) @(posedge mclk);
    chk("pdown held", 32'h2, {30'h0, lnk.pm_state});
    wr(iepm_pkg::AHB_FLAGS, 32'h3);
    repeat (20)
    begin
      @(posedge mclk);
      n += (lnk.isr_start === 1'h1);
    end
    chk("isr start", 32'h1, n);
    chk("pdown exit", 32'h0, {30'h0, lnk.pm_state});
  endtask : t_pdown
  initial
  begin
    repeat (8) @(posedge mclk);
    // Reset held until clock is steady
    rst_n <= 1'h1;
    @(posedge mclk);
    t_regs();
    t_gate();
    t_terms();
    t_idle();
    t_idle_rst();
    t_pdown();
    report_and_stop();
  end
  initial
  begin
    #1000000;
    errors++;
    report_and_stop();
  end
endmodule : irq_enable_and_power_modes_tb_top
